// >>> include/vstc_pkg.sv
// video sync timing control: shared offsets, reset values, bit positions, timing counts
// assumes a single 100 MHz system clock and byte-wide register access by subaddress
package vstc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ***************************************************************
    // register subaddresses and reset values
    // ***************************************************************
    localparam logic [7:0] ADDR_SYNC_OPT = 8'h38;
    localparam logic [7:0] ADDR_TIM_CTL = 8'h39;
    localparam logic [7:0] ADDR_HS_START = 8'h3A;
    localparam logic [7:0] ADDR_HS_END = 8'h3B;
    localparam logic [7:0] ADDR_EXP_CHG = 8'h3C;
    localparam logic [7:0] RST_SYNC_OPT = 8'h81;
    localparam logic [7:0] RST_TIM_CTL = 8'h00;
    localparam logic [7:0] RST_HS_START = 8'h0F;
    localparam logic [7:0] RST_HS_END = 8'h3C;
    localparam logic [7:0] RST_EXP_CHG = 8'h21;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int SO_LV_FALL = 7;
    localparam int SO_ZV_VSYNC = 4;
    localparam int SO_QUICK = 3;
    localparam int SO_AWB_QTR = 1;
    localparam int TC_PCLK_GATE = 6;
    localparam int TC_VS_SAME = 5;
    localparam int TC_CHS_ON_LV = 4;
    localparam int TC_LV_ON_CHS = 3;
    localparam int TC_TRISTATE = 2;
    localparam int TC_HS_START_MSB = 1;
    localparam int TC_HS_END_MSB = 0;
    localparam int EC_STEP_HI = 7;
    localparam int EC_STEP_LO = 5;
    localparam int EC_MODE_HI = 4;
    localparam int EC_MODE_LO = 3;
    localparam int EC_FASTEST = 2;
    localparam int EC_FAST = 1;
    localparam int EC_SLOWEST = 0;
    localparam logic [2:0] STEP_MAX_SHIFT = 3'h5;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int CLK_MHZ = 100;
    localparam int LV_DELAY_NS = 10;
    localparam int LV_DELAY_CYC_RAW = (LV_DELAY_NS * CLK_MHZ) / 1000;
    localparam int LV_DELAY_CYC = (LV_DELAY_CYC_RAW < 1) ? 1 : LV_DELAY_CYC_RAW;
    localparam int PCLK_HALF = 2;
    localparam logic [1:0] PH_LAST = 2'(2 * PCLK_HALF - 1);
    localparam logic [1:0] PH_RISE = 2'(PCLK_HALF - 1);
    localparam logic [1:0] PH_LV_DLY = 2'(PCLK_HALF - 1 + LV_DELAY_CYC);
    localparam int H_TOTAL = 400;
    localparam int H_ACTIVE = 352;
    localparam int V_TOTAL = 312;
    localparam int V_ACTIVE = 288;
    localparam int VS_LINES = 3;
    localparam int AE_SLOW_FIELDS = 8;
    localparam int AWB_SLOW_FIELDS = 16;
endpackage : vstc_pkg

// >>> include/vstc_cfg_if.sv
// configuration bundle from the register bank to the timing and settle logic
// assumes one producer (register bank) and any number of readers
`timescale 1ns/1ps
interface vstc_cfg_if;
    logic [7:0] sync_opt;
    logic [7:0] tim_ctl;
    logic [7:0] hs_start_lo;
    logic [7:0] hs_end_lo;
    logic [7:0] exp_chg;
    modport src (output sync_opt, tim_ctl, hs_start_lo, hs_end_lo, exp_chg);
    modport dst (input sync_opt, tim_ctl, hs_start_lo, hs_end_lo, exp_chg);
endinterface : vstc_cfg_if

// >>> rtl/vstc_regs.sv
// register bank at subaddresses 0x38..0x3c, byte writes, registered reads
// assumes the serial control slave delivers one-cycle write and read strobes
`timescale 1ns/1ps
module vstc_regs
    import vstc_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // register port
    input wire logic [vstc_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [vstc_pkg::DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [vstc_pkg::DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // configuration out
    vstc_cfg_if.src cfg
);
    // ***************************************************************
    // storage: every bit kept, reserved ones included
    // ***************************************************************
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            cfg.sync_opt <= RST_SYNC_OPT;
            cfg.tim_ctl <= RST_TIM_CTL;
            cfg.hs_start_lo <= RST_HS_START;
            cfg.hs_end_lo <= RST_HS_END;
            cfg.exp_chg <= RST_EXP_CHG;
        end else if (i_reg_wr) begin
            if (i_reg_addr == ADDR_SYNC_OPT) begin
                cfg.sync_opt <= i_reg_wdata;
            end else if (i_reg_addr == ADDR_TIM_CTL) begin
                cfg.tim_ctl <= i_reg_wdata;
            end else if (i_reg_addr == ADDR_HS_START) begin
                cfg.hs_start_lo <= i_reg_wdata;
            end else if (i_reg_addr == ADDR_HS_END) begin
                cfg.hs_end_lo <= i_reg_wdata;
            end else if (i_reg_addr == ADDR_EXP_CHG) begin
                cfg.exp_chg <= i_reg_wdata;
            end
        end
    end

    // ***************************************************************
    // readback, unmapped reads return zero
    // ***************************************************************
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (!i_reg_rd) begin
                o_reg_rdata <= o_reg_rdata;
            end else if (i_reg_addr == ADDR_SYNC_OPT) begin
                o_reg_rdata <= cfg.sync_opt;
            end else if (i_reg_addr == ADDR_TIM_CTL) begin
                o_reg_rdata <= cfg.tim_ctl;
            end else if (i_reg_addr == ADDR_HS_START) begin
                o_reg_rdata <= cfg.hs_start_lo;
            end else if (i_reg_addr == ADDR_HS_END) begin
                o_reg_rdata <= cfg.hs_end_lo;
            end else if (i_reg_addr == ADDR_EXP_CHG) begin
                o_reg_rdata <= cfg.exp_chg;
            end else begin
                o_reg_rdata <= 8'h00;
            end
        end
    end
endmodule : vstc_regs

// >>> rtl/vstc_settle.sv
// exposure and white balance settling tracker after a camera mode change
// assumes i_field_start pulses once per field
`timescale 1ns/1ps
module vstc_settle
    import vstc_pkg::*;
#(
    parameter int AE_FIELDS = AE_SLOW_FIELDS,
    parameter int AWB_FIELDS = AWB_SLOW_FIELDS
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // events
    input wire logic i_mode_change,
    input wire logic i_field_start,
    // configuration
    vstc_cfg_if.dst cfg,
    // status
    output logic o_exposure_stable,
    output logic o_wb_stable
);
    logic [7:0] fields;
    logic [7:0] ae_need;
    logic [7:0] awb_need;
    logic [7:0] next_fields;

    // ***************************************************************
    // field count since last mode change
    // ***************************************************************
    always_comb begin
        ae_need = cfg.sync_opt[SO_QUICK] ? 8'h01 : 8'(AE_FIELDS);
        if (cfg.sync_opt[SO_QUICK]) begin
            awb_need = 8'h01;
        end else if (cfg.sync_opt[SO_AWB_QTR]) begin
            awb_need = 8'(AWB_FIELDS / 4);
        end else begin
            awb_need = 8'(AWB_FIELDS);
        end
        next_fields = (i_field_start && fields != 8'hFF) ? fields + 8'h01 : fields;
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            fields <= 8'h00;
            o_exposure_stable <= 1'b0;
            o_wb_stable <= 1'b0;
        end else if (i_mode_change) begin
            fields <= 8'h00;
            o_exposure_stable <= 1'b0;
            o_wb_stable <= 1'b0;
        end else begin
            fields <= next_fields;
            o_exposure_stable <= next_fields >= ae_need;
            o_wb_stable <= next_fields >= awb_need;
        end
    end

    property p_quick_first;
        @(posedge i_clk_sys) disable iff (i_reset)
        (cfg.sync_opt[SO_QUICK] && i_field_start && !i_mode_change) |=> o_exposure_stable;
    endproperty
    a_quick_first: assert property (p_quick_first)
        else $error("quick mode not stable after first field");

    property p_awb_quarter;
        @(posedge i_clk_sys) disable iff (i_reset)
        (!cfg.sync_opt[SO_QUICK] && cfg.sync_opt[SO_AWB_QTR] && !i_mode_change
            && next_fields == 8'(AWB_FIELDS / 4)) |=> o_wb_stable;
    endproperty
    a_awb_quarter: assert property (p_awb_quarter)
        else $error("white balance not stable at quarter time");
endmodule : vstc_settle

// >>> rtl/vstc_top.sv
// video sync timing control: registers, sync generation and timing pin control
// assumes register strobes from the serial control slave, pins resolved outside
`timescale 1ns/1ps

// Overview of operation
// - lv_fall bit: line valid changes on pclk fall, else 10 ns after rise
// - zv bit selects zv-style vertical sync, else normal tv vertical sync
// - quick bit: first vsync after mode change gives settled exposure
// - quarter bit in slow mode: white balance settles four times faster
// - gate bit: pixel clock toggles only while line valid is high
// - same bit: equal line-valid to vsync-fall interval in both fields
// - composite sync driven on the line-valid pin when selected
// - line valid driven on the composite sync pin when selected
// - tristate bit releases odd flag, composite sync, line valid, pclk
// - sync start is nine bits: low byte plus control bit 1
// - sync end is nine bits: low byte plus control bit 0
// - banding filter: step code sets minimum exposure fraction
// - bits 2,1,0 pick fastest, fast, slowest adjustment rate
// - bits 4,3 pick exposure and gain change mode
module vstc_top
    import vstc_pkg::*;
#(
    parameter int HT = H_TOTAL,
    parameter int HA = H_ACTIVE,
    parameter int VT = V_TOTAL,
    parameter int VA = V_ACTIVE,
    parameter int VSL = VS_LINES,
    parameter int AE_FIELDS = AE_SLOW_FIELDS,
    parameter int AWB_FIELDS = AWB_SLOW_FIELDS
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // register port
    input wire logic [vstc_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [vstc_pkg::DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [vstc_pkg::DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // camera state inputs
    input wire logic i_mode_change,
    input wire logic i_banding_filter_en,
    // timing pins
    output logic o_pclk,
    output logic o_pclk_oe,
    output logic o_line_valid,
    output logic o_line_valid_oe,
    output logic o_composite_horizontal_sync,
    output logic o_composite_horizontal_sync_oe,
    output logic o_odd_field_flag,
    output logic o_odd_field_flag_oe,
    output logic o_vertical_sync_pulse,
    // exposure control outputs
    output logic [2:0] o_min_exposure_shift,
    output logic [2:0] o_exposure_rate,
    output logic [1:0] o_exposure_change_mode,
    output logic o_exposure_stable,
    output logic o_wb_stable
);
    localparam int VB = VT - VA;

    vstc_cfg_if cfg ();

    logic [1:0] ph;
    logic [1:0] next_ph;
    logic pclk_int;
    logic [8:0] hcnt;
    logic [8:0] vcnt;
    logic [8:0] next_hcnt;
    logic [8:0] next_vcnt;
    logic pix_adv;
    logic line_end;
    logic frame_end;
    logic odd;
    logic lv;
    logic chs;
    logic vs_int;
    logic [8:0] hs_start_act;
    logic [8:0] hs_end_act;

    // ***************************************************************
    // register bank and settle tracker
    // ***************************************************************
    vstc_regs u_regs (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata),
        .o_reg_rvalid(o_reg_rvalid),
        .cfg(cfg.src)
    );

    vstc_settle #(
        .AE_FIELDS(AE_FIELDS),
        .AWB_FIELDS(AWB_FIELDS)
    ) u_settle (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_mode_change(i_mode_change),
        .i_field_start(frame_end),
        .cfg(cfg.dst),
        .o_exposure_stable(o_exposure_stable),
        .o_wb_stable(o_wb_stable)
    );

    // ***************************************************************
    // pixel phase and counters
    // ***************************************************************
    function automatic logic active_at(input logic [8:0] h, input logic [8:0] v);
        active_at = (h < 9'(HA)) && (v >= 9'(VB));
    endfunction : active_at

    always_comb begin
        pix_adv = (ph == PH_LAST);
        next_ph = pix_adv ? 2'h0 : ph + 2'h1;
        line_end = pix_adv && (hcnt == 9'(HT - 1));
        frame_end = line_end && (vcnt == 9'(VT - 1));
        next_hcnt = line_end ? 9'h000 : (pix_adv ? hcnt + 9'h001 : hcnt);
        if (frame_end) begin
            next_vcnt = 9'h000;
        end else if (line_end) begin
            next_vcnt = vcnt + 9'h001;
        end else begin
            next_vcnt = vcnt;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            ph <= 2'h0;
            pclk_int <= 1'b0;
            hcnt <= 9'h000;
            vcnt <= 9'h000;
            odd <= 1'b1;
        end else begin
            ph <= next_ph;
            pclk_int <= (next_ph >= 2'(PCLK_HALF));
            hcnt <= next_hcnt;
            vcnt <= next_vcnt;
            odd <= frame_end ? ~odd : odd;
        end
    end

    // ***************************************************************
    // line valid timing
    // ***************************************************************
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            lv <= 1'b0;
        end else if (cfg.sync_opt[SO_LV_FALL]) begin
            if (pix_adv) begin
                lv <= active_at(next_hcnt, next_vcnt);
            end
        end else if (ph == PH_LV_DLY) begin
            lv <= active_at(hcnt, vcnt);
        end
    end

    // ***************************************************************
    // horizontal sync positions, latched per line
    // ***************************************************************
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            hs_start_act <= {RST_TIM_CTL[TC_HS_START_MSB], RST_HS_START};
            hs_end_act <= {RST_TIM_CTL[TC_HS_END_MSB], RST_HS_END};
        end else if (line_end) begin
            hs_start_act <= {cfg.tim_ctl[TC_HS_START_MSB], cfg.hs_start_lo};
            hs_end_act <= {cfg.tim_ctl[TC_HS_END_MSB], cfg.hs_end_lo};
        end
    end

    // ***************************************************************
    // composite and vertical sync
    // ***************************************************************
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            chs <= 1'b0;
            vs_int <= 1'b0;
        end else begin
            // sync window assumes end above start, else no pulse
            chs <= (hcnt >= hs_start_act) && (hcnt < hs_end_act);
            if (odd || cfg.tim_ctl[TC_VS_SAME]) begin
                vs_int <= vcnt < 9'(VSL);
            end else begin
                vs_int <= ((vcnt == 9'h000) && (hcnt >= 9'(HT / 2)))
                    || ((vcnt != 9'h000) && (vcnt < 9'(VSL)))
                    || ((vcnt == 9'(VSL)) && (hcnt < 9'(HT / 2)));
            end
        end
    end

    // ***************************************************************
    // output pins
    // ***************************************************************
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_pclk <= 1'b0;
            o_line_valid <= 1'b0;
            o_composite_horizontal_sync <= 1'b0;
            o_odd_field_flag <= 1'b0;
            o_vertical_sync_pulse <= 1'b0;
        end else begin
            o_pclk <= pclk_int && (lv || !cfg.tim_ctl[TC_PCLK_GATE]);
            o_line_valid <= cfg.tim_ctl[TC_CHS_ON_LV] ? chs : lv;
            o_composite_horizontal_sync <= cfg.tim_ctl[TC_LV_ON_CHS] ? lv : chs;
            o_odd_field_flag <= odd;
            // zv style is active high, tv style active low
            o_vertical_sync_pulse <= cfg.sync_opt[SO_ZV_VSYNC] ? vs_int : ~vs_int;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_pclk_oe <= 1'b0;
            o_line_valid_oe <= 1'b0;
            o_composite_horizontal_sync_oe <= 1'b0;
            o_odd_field_flag_oe <= 1'b0;
        end else begin
            o_pclk_oe <= !cfg.tim_ctl[TC_TRISTATE];
            o_line_valid_oe <= !cfg.tim_ctl[TC_TRISTATE];
            o_composite_horizontal_sync_oe <= !cfg.tim_ctl[TC_TRISTATE];
            o_odd_field_flag_oe <= !cfg.tim_ctl[TC_TRISTATE];
        end
    end

    // ***************************************************************
    // exposure control decode
    // ***************************************************************
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_min_exposure_shift <= 3'h0;
            o_exposure_rate <= 3'h0;
            o_exposure_change_mode <= 2'h0;
        end else begin
            if (!i_banding_filter_en) begin
                o_min_exposure_shift <= 3'h0;
            end else if (cfg.exp_chg[EC_STEP_HI:EC_STEP_LO] > STEP_MAX_SHIFT) begin
                o_min_exposure_shift <= STEP_MAX_SHIFT;
            end else begin
                o_min_exposure_shift <= cfg.exp_chg[EC_STEP_HI:EC_STEP_LO];
            end
            o_exposure_rate <= {cfg.exp_chg[EC_FASTEST], cfg.exp_chg[EC_FAST],
                cfg.exp_chg[EC_SLOWEST]};
            o_exposure_change_mode <= cfg.exp_chg[EC_MODE_HI:EC_MODE_LO];
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    property p_lv_fall;
        (cfg.sync_opt[SO_LV_FALL] && $past(cfg.sync_opt[SO_LV_FALL]) && $changed(lv))
            |-> $fell(pclk_int);
    endproperty
    a_lv_fall: assert property (p_lv_fall)
        else $error("line valid moved off the pclk falling edge");

    property p_lv_delay;
        (!cfg.sync_opt[SO_LV_FALL] && !$past(cfg.sync_opt[SO_LV_FALL]) && $changed(lv))
            |-> (pclk_int && $past(pclk_int) && !$past(pclk_int, 2));
    endproperty
    a_lv_delay: assert property (p_lv_delay)
        else $error("line valid not one cycle after pclk rise");

    property p_vs_polarity;
        (cfg.sync_opt[SO_ZV_VSYNC] && $stable(cfg.sync_opt) && vcnt == 9'(VT / 2))
            ##1 (vcnt == 9'(VT / 2)) |-> !o_vertical_sync_pulse;
    endproperty
    a_vs_polarity: assert property (p_vs_polarity)
        else $error("zv vsync active outside its window");

    property p_pclk_gate;
        (cfg.tim_ctl[TC_PCLK_GATE] && !lv) |=> !o_pclk;
    endproperty
    a_pclk_gate: assert property (p_pclk_gate)
        else $error("pixel clock toggled with line valid low");

    property p_vs_same;
        (cfg.tim_ctl[TC_VS_SAME] && line_end && vcnt == 9'(VSL - 1)) ##1 1'b1 |=> !vs_int;
    endproperty
    a_vs_same: assert property (p_vs_same)
        else $error("vsync not ended at the line boundary");

    property p_swap_lv;
        (cfg.tim_ctl[TC_CHS_ON_LV] && cfg.tim_ctl[TC_LV_ON_CHS])
            |=> (o_line_valid == $past(chs)) && (o_composite_horizontal_sync == $past(lv));
    endproperty
    a_swap_lv: assert property (p_swap_lv)
        else $error("swapped sync pins carry wrong signals");

    property p_tristate;
        cfg.tim_ctl[TC_TRISTATE] |=> !(o_pclk_oe || o_line_valid_oe
            || o_composite_horizontal_sync_oe || o_odd_field_flag_oe);
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("timing pin driven while released");

    property p_hs_boundary;
        $changed(hs_start_act) || $changed(hs_end_act) |-> $past(line_end);
    endproperty
    a_hs_boundary: assert property (p_hs_boundary)
        else $error("sync position changed mid line");

    property p_step_clamp;
        (i_banding_filter_en && cfg.exp_chg[EC_STEP_HI:EC_STEP_LO] == 3'h7)
            |=> o_min_exposure_shift == 3'h5;
    endproperty
    a_step_clamp: assert property (p_step_clamp)
        else $error("exposure step code not clamped");
endmodule : vstc_top

// >>> tb/vstc_host_model.sv
// host capture model: counts line-valid pulses seen on the line-valid pin
// assumes pins are sampled on the system clock and a released pin reads low
`timescale 1ns/1ps
module vstc_host_model (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_line_valid,
    input wire logic i_line_valid_oe,
    output logic [15:0] o_lines
);
    logic last;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_lines <= 16'h0000;
            last <= 1'b0;
        end else begin
            if (i_line_valid_oe && i_line_valid && !last) o_lines <= o_lines + 16'h0001;
            last <= i_line_valid_oe & i_line_valid;
        end
    end
endmodule : vstc_host_model

// >>> tb/video_sync_timing_control_tb.sv
// self-checking bench for the sync timing register bank and its pins
// assumes the small timing parameters so a field is 800 clock cycles
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module video_sync_timing_control_tb;
    import vstc_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, mc = 0, bf = 0, rv;
    logic [7:0] addr = 0, wd = 0, rdat, r;
    logic pclk, pc_oe, lv, lv_oe, chs, chs_oe, odd, odd_oe, vs, es, ws;
    logic [2:0] sh, rate;
    logic [1:0] md;
    logic [15:0] lines;
    logic [7:0] tab [5] = '{RST_SYNC_OPT, RST_TIM_CTL, RST_HS_START, RST_HS_END, RST_EXP_CHG};
    int errors = 0, num_checks = 0, n;
    int c_vs, c_odd, c_lv, c_chs, c_lvh, c_ln;
    always #5 clk = ~clk;
    vstc_top #(.HT(20), .HA(12), .VT(10), .VA(6), .VSL(2)) DUT (
        .i_clk_sys(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wdata(wd),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
        .i_mode_change(mc), .i_banding_filter_en(bf), .o_pclk(pclk), .o_pclk_oe(pc_oe),
        .o_line_valid(lv), .o_line_valid_oe(lv_oe), .o_composite_horizontal_sync(chs),
        .o_composite_horizontal_sync_oe(chs_oe), .o_odd_field_flag(odd),
        .o_odd_field_flag_oe(odd_oe), .o_vertical_sync_pulse(vs), .o_min_exposure_shift(sh),
        .o_exposure_rate(rate), .o_exposure_change_mode(md), .o_exposure_stable(es),
        .o_wb_stable(ws));
    vstc_host_model HOST (.i_clk_sys(clk), .i_reset(rst), .i_line_valid(lv),
        .i_line_valid_oe(lv_oe), .o_lines(lines));
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask : wr8
    task automatic chkreg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1;
        @(negedge clk);
        rd = 0;
        `CHK(rv, 1'b1)
        `CHK(rdat, e)
    endtask : chkreg
    task automatic t_regs;
        for (int k = 0; k < 5; k++) chkreg(8'h38 + 8'(k), tab[k]);
        wr8(8'h3a, 8'ha5);
        wr8(8'h3b, 8'hc3);
        wr8(8'h39, 8'h03);
        chkreg(8'h3a, 8'ha5);
        chkreg(8'h3b, 8'hc3);
        chkreg(8'h39, 8'h03);
        wr8(8'h40, 8'h55);
        chkreg(8'h40, 8'h00);
        wr8(8'h39, 8'h00);
    endtask : t_regs
    task automatic t_exp;
        bf = 1;
        for (int c = 0; c < 8; c++) begin
            wr8(8'h3c, {3'(c), 5'h1a});
            repeat (2) @(negedge clk);
            `CHK(sh, (c > 5) ? 3'h5 : 3'(c))
            `CHK(rate, 3'h2)
            `CHK(md, 2'h3)
        end
        bf = 0;
        repeat (2) @(negedge clk);
        `CHK(sh, 3'h0)
    endtask : t_exp
    task automatic t_tri(input logic [7:0] v, input logic [3:0] e);
        wr8(8'h39, v);
        repeat (2) @(negedge clk);
        `CHK({pc_oe, lv_oe, chs_oe, odd_oe}, e)
    endtask : t_tri
    task automatic tog(input logic [7:0] v);
        logic p, pl;
        wr8(8'h39, v);
        @(negedge clk);
        n = 0;
        p = pclk;
        pl = lv;
        repeat (400) begin
            @(negedge clk);
            if (pclk !== p && !lv && !pl) n++;
            p = pclk;
            pl = lv;
        end
    endtask : tog
    task automatic cnt(input logic [7:0] so, input logic [7:0] tc);
        logic pl;
        wr8(8'h38, so);
        wr8(8'h39, tc);
        repeat (100) @(negedge clk);
        c_vs = 0;
        c_odd = 0;
        c_lv = 0;
        c_chs = 0;
        c_lvh = 0;
        c_ln = int'(lines);
        pl = lv;
        repeat (1600) begin
            @(negedge clk);
            if (vs === 1'b1) c_vs++;
            if (odd === 1'b1) c_odd++;
            if (lv === 1'b1) c_lv++;
            if (chs === 1'b1) c_chs++;
            if (lv !== pl && pclk === 1'b1) c_lvh++;
            pl = lv;
        end
        c_ln = int'(lines) - c_ln;
    endtask : cnt
    task automatic t_pins;
        wr8(8'h3a, 8'h04);
        wr8(8'h3b, 8'h08);
        cnt(8'h81, 8'h00);
        `CHK(c_vs, 1280)
        `CHK(c_odd, 800)
        `CHK(c_chs, 320)
        `CHK(c_lv, 576)
        `CHK(c_lvh, 0)
        `CHK(c_ln, 12)
        cnt(8'h91, 8'h19);
        `CHK(c_vs, 320)
        `CHK(c_lv, 1280)
        `CHK(c_chs, 576)
        `CHK(c_ln, 20)
        cnt(8'h01, 8'h23);
        `CHK(c_vs, 1280)
        `CHK(c_chs, 0)
        `CHK(c_lvh, 24)
        wr8(8'h38, 8'h81);
    endtask : t_pins
    task automatic t_settle;
        wr8(8'h38, 8'h8b);
        @(negedge clk);
        mc = 1;
        @(negedge clk);
        mc = 0;
        `CHK(es, 1'b0)
        repeat (1700) @(negedge clk);
        `CHK(es, 1'b1)
        `CHK(ws, 1'b1)
        wr8(8'h38, 8'h83);
        @(negedge clk);
        mc = 1;
        @(negedge clk);
        mc = 0;
        `CHK(ws, 1'b0)
        repeat (2350) @(negedge clk);
        `CHK(ws, 1'b0)
        repeat (900) @(negedge clk);
        `CHK(ws, 1'b1)
        `CHK(es, 1'b0)
    endtask : t_settle
    task automatic conclude;
        if (errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    initial begin
        #400000;
        errors++;
        conclude();
    end
    initial begin
        repeat (5) @(negedge clk);
        rst = 0;
        t_regs();
        t_exp();
        t_tri(8'h04, 4'h0);
        t_tri(8'h00, 4'hf);
        tog(8'h40);
        `CHK(n, 0)
        tog(8'h00);
        `CHK(n > 0, 1'b1)
        `CHK(lines != 16'h0000, 1'b1)
        t_pins();
        t_settle();
        conclude();
    end
endmodule : video_sync_timing_control_tb
